/* verilog/sbx_pkg.sv */
// Package of encodings, field values and states for the shift/branch/bit unit.
`default_nettype none
package sbx_pkg;

  // ---------------------------------------------------------------------
  // Condition flag positions in the five-bit flag vector {X,N,Z,V,C}
  // ---------------------------------------------------------------------
  localparam int FLG_X = 4;
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;

  // ---------------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------------
  localparam logic [3:0] OP_SHIFT   = 4'he;
  localparam logic [6:0] OP_MSHIFT  = 7'h70;
  localparam logic [3:0] OP_BRANCH  = 4'h6;
  localparam logic [3:0] OP_BIT     = 4'h0;
  localparam logic [2:0] BIT_DYN    = 3'h5;
  localparam logic [9:0] OP_BIT_STA = 10'h021;
  localparam logic [1:0] SH_ARITH   = 2'h0;
  localparam logic [1:0] SZ_BYTE    = 2'h0;
  localparam logic [1:0] SZ_WORD    = 2'h1;
  localparam logic [1:0] SZ_LONG    = 2'h2;
  localparam logic [1:0] SZ_MEM     = 2'h3;
  localparam logic [4:0] MSB_BYTE   = 5'h07;
  localparam logic [4:0] MSB_WORD   = 5'h0f;
  localparam logic [4:0] MSB_LONG   = 5'h1f;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] MASK_WORD = 32'h0000_ffff;
  localparam logic [31:0] MASK_LONG = 32'hffff_ffff;
  localparam logic [5:0] IMM_CNT_MAX = 6'h08;
  localparam logic [5:0] MEM_CNT     = 6'h01;

  // ---------------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------------
  localparam logic [2:0] MODE_DREG   = 3'h0;
  localparam logic [2:0] MODE_MEM_MIN = 3'h2;
  localparam logic [2:0] MODE_MEM_MAX = 3'h6;
  localparam logic [2:0] MODE_ABS     = 3'h7;
  localparam logic [2:0] ABS_REG_MAX  = 3'h1;

  // ---------------------------------------------------------------------
  // Branch displacement selectors and condition codes
  // ---------------------------------------------------------------------
  localparam logic [7:0]  DISP_WORD = 8'h00;
  localparam logic [7:0]  DISP_LONG = 8'hff;
  localparam logic [31:0] PC_STEP   = 32'h0000_0002;
  localparam logic [3:0] COND_FIRST                  = 4'h2;
  localparam logic [3:0] UNSIGNED_ABOVE_TEST         = 4'h2;
  localparam logic [3:0] UNSIGNED_BELOW_OR_SAME_TEST = 4'h3;
  localparam logic [3:0] CARRY_CLEAR_TEST            = 4'h4;
  localparam logic [3:0] CARRY_SET_TEST              = 4'h5;
  localparam logic [3:0] ZERO_CLEAR_TEST             = 4'h6;
  localparam logic [3:0] ZERO_SET_TEST               = 4'h7;
  localparam logic [3:0] OVERFLOW_CLEAR_TEST         = 4'h8;
  localparam logic [3:0] OVERFLOW_SET_TEST           = 4'h9;
  localparam logic [3:0] POSITIVE_TEST               = 4'ha;
  localparam logic [3:0] NEGATIVE_TEST               = 4'hb;
  localparam logic [3:0] SIGNED_NOT_LESS_TEST        = 4'hc;
  localparam logic [3:0] SIGNED_BELOW_TEST           = 4'hd;
  localparam logic [3:0] SIGNED_ABOVE_TEST           = 4'he;
  localparam logic [3:0] SIGNED_NOT_ABOVE_TEST       = 4'hf;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DEC   = 6'h02,
    ST_EXT   = 6'h04,
    ST_MEM   = 6'h08,
    ST_SHIFT = 6'h10,
    ST_EXEC  = 6'h20
  } sbx_state_t;

endpackage

`default_nettype wire

/* verilog/sbx_exec.sv */
// Executes arithmetic shifts, conditional branches and bit test-and-invert.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Right shift refills the sign bit; each out bit goes to C and X.
// - X takes last bit shifted out; unchanged for zero count.
// - N equals result MSB at operand size.
// - V set if MSB changes at any step of the shift.
// - C takes last bit shifted out; cleared for zero count.
// - Immediate count field 1-7 is the count; zero means eight.
// - Register count is that data register modulo 64.
// - Direction bit 0 shifts right, 1 shifts left.
// - Size 00 byte, 01 word, 10 long; low three bits name register.
// - Memory shift takes only memory-alterable modes; others are illegal.
// - Taken branch loads opcode address plus two plus displacement.
// - Displacement is a signed byte distance from that base.
// - Zero short displacement fetches one 16-bit extension word.
// - All-ones byte displacement selects a 32-bit two-word displacement.
// - Bit operation samples destination bit, then writes it inverted.
// - Z is inverse of sampled bit; other flags unchanged.
// - Register destination is 32 bits, bit number modulo 32.
// - Memory destination is a byte, bit number modulo 8.
// - Bit zero is always the least significant bit.
// - Bit number from extension word or from a named data register.
// - Left shift inserts zeros, top out bit goes to C and X.
// - Memory shift is one position on a word operand.
module sbx_exec
  import sbx_pkg::*;
#(
  parameter bit LONG_DISP_EN = 1'b1
) (
  input  wire logic          clock_in,
  input  wire logic          sys_rst_in,
  input  wire logic          op_valid_in,
  input  wire logic [15:0]   opcode_in,
  input  wire logic [31:0]   pc_in,
  input  wire logic [4:0]    flags_in,
  input  wire logic [255:0]  dreg_file_in,
  input  wire logic          ext_valid_in,
  input  wire logic [15:0]   ext_word_in,
  input  wire logic          mem_valid_in,
  input  wire logic [15:0]   mem_rdata_in,
  output logic               op_ready_out,
  output logic               ext_req_out,
  output logic               mem_req_out,
  output logic               done_out,
  output logic               illegal_out,
  output logic               flags_we_out,
  output logic [4:0]         flags_out,
  output logic               dreg_we_out,
  output logic [2:0]         dreg_idx_out,
  output logic [31:0]        dreg_data_out,
  output logic               mem_wr_out,
  output logic               mem_byte_out,
  output logic [15:0]        mem_wdata_out,
  output logic               pc_we_out,
  output logic [31:0]        pc_out
);

  function automatic logic [31:0] sext(input logic [31:0] v,
                                       input logic [1:0]  sz);
    sext = (sz == SZ_BYTE) ? {{24{v[7]}}, v[7:0]} :
           (sz == SZ_WORD) ? {{16{v[15]}}, v[15:0]} : v;
  endfunction

  sbx_state_t  state_r;
  sbx_state_t  state_nxt;
  logic [15:0] op_r;
  logic [31:0] pc_r;
  logic [31:0] orig_r;
  logic [31:0] opnd_r;
  logic [31:0] ext_r;
  logic [5:0]  cnt_r;
  logic [1:0]  ext_left_r;
  logic        v_r;
  logic        last_r;
  logic        shifted_r;
  logic        cond_true;

  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  wire [2:0] ea_mode = op_r[5:3];
  wire [2:0] ea_reg  = op_r[2:0];
  wire mem_alt = (ea_mode >= MODE_MEM_MIN && ea_mode <= MODE_MEM_MAX) ||
                 (ea_mode == MODE_ABS && ea_reg <= ABS_REG_MAX);
  wire is_rsh  = op_r[15:12] == OP_SHIFT && op_r[4:3] == SH_ARITH &&
                 op_r[7:6] != SZ_MEM;
  wire is_msh  = op_r[15:9] == OP_MSHIFT && op_r[7:6] == SZ_MEM;
  wire is_br   = op_r[15:12] == OP_BRANCH;
  wire is_bdyn = op_r[15:12] == OP_BIT && op_r[8:6] == BIT_DYN;
  wire is_bsta = op_r[15:6] == OP_BIT_STA;
  wire is_bit  = is_bdyn | is_bsta;
  wire is_sh   = is_rsh | is_msh;
  wire bit_mem = ea_mode != MODE_DREG;
  wire left    = op_r[8];
  wire [7:0] disp8   = op_r[7:0];
  wire word_disp = disp8 == DISP_WORD;
  wire long_disp = disp8 == DISP_LONG;
  wire op_ok = is_rsh | (is_msh & mem_alt) |
               (is_br & op_r[11:8] >= COND_FIRST &
                (!long_disp | LONG_DISP_EN)) |
               (is_bit & (!bit_mem | mem_alt));
  wire [1:0] ext_need = is_br ? (word_disp ? 2'h1 : long_disp ? 2'h2 : 2'h0)
                              : {1'b0, is_bsta};
  wire need_mem = is_msh | (is_bit & bit_mem);

  // Size picks the working width: memory shifts are words, memory bit
  // operations are bytes and register bit operations are long.
  wire [1:0] size = is_rsh ? op_r[7:6] : is_msh ? SZ_WORD :
                    bit_mem ? SZ_BYTE : SZ_LONG;
  wire [4:0]  msb  = (size == SZ_BYTE) ? MSB_BYTE :
                     (size == SZ_WORD) ? MSB_WORD : MSB_LONG;
  wire [31:0] mask = (size == SZ_BYTE) ? MASK_BYTE :
                     (size == SZ_WORD) ? MASK_WORD : MASK_LONG;
  wire [31:0] cnt_src = dreg_file_in[{op_r[11:9], 5'h00} +: 32];
  wire [31:0] dst_reg = dreg_file_in[{ea_reg, 5'h00} +: 32];
  wire [5:0]  cnt_reg_val = cnt_src[5:0];
  wire [5:0]  cnt_load = is_msh ? MEM_CNT : op_r[5] ? cnt_reg_val :
                         (op_r[11:9] == 3'h0) ? IMM_CNT_MAX :
                         {3'h0, op_r[11:9]};

  // -----------------------------------------------------------------------
  // One shift position per cycle
  // -----------------------------------------------------------------------
  // The operand is sign-extended to 32 bits on load, so a right shift of
  // the full word refills the sized sign bit for every size.
  wire [4:0]  msb_m1    = msb - 5'h01;
  wire        msb_chg   = opnd_r[msb] ^ opnd_r[msb_m1];
  wire        out_bit   = left ? opnd_r[msb] : opnd_r[0];
  wire [31:0] opnd_step = left ? {opnd_r[30:0], 1'b0}
                               : {opnd_r[31], opnd_r[31:1]};
  wire [31:0] sh_res = (orig_r & ~mask) | (opnd_r & mask);
  wire [4:0]  sh_flags = {shifted_r ? last_r : flags_in[FLG_X],
                          opnd_r[msb],
                          ~|(opnd_r & mask),
                          v_r,
                          shifted_r & last_r};

  // -----------------------------------------------------------------------
  // Bit test-and-invert
  // -----------------------------------------------------------------------
  wire [31:0] bit_src  = is_bsta ? ext_r : cnt_src;
  wire [4:0]  bitn     = bit_mem ? {2'h0, bit_src[2:0]}
                                 : bit_src[4:0];
  wire [31:0] bit_mask = 32'h0000_0001 << bitn;
  wire        tested   = |(orig_r & bit_mask);
  wire [31:0] bit_res  = orig_r ^ bit_mask;
  wire [4:0]  bit_flags = {flags_in[FLG_X], flags_in[FLG_N], ~tested,
                           flags_in[FLG_V], flags_in[FLG_C]};

  // -----------------------------------------------------------------------
  // Branch target
  // -----------------------------------------------------------------------
  wire [31:0] disp = long_disp ? ext_r :
                     word_disp ? {{16{ext_r[15]}}, ext_r[15:0]} :
                     {{24{disp8[7]}}, disp8};
  wire [31:0] pc_base   = pc_r + PC_STEP;
  wire [31:0] pc_fall   = pc_base + {29'h0, ext_need, 1'b0};
  wire [31:0] pc_target = cond_true ? pc_base + disp : pc_fall;
  wire fc = flags_in[FLG_C];
  wire fv = flags_in[FLG_V];
  wire fz = flags_in[FLG_Z];
  wire fn = flags_in[FLG_N];

  always_comb begin
    unique case (op_r[11:8])
      UNSIGNED_ABOVE_TEST:         cond_true = !fc && !fz;
      UNSIGNED_BELOW_OR_SAME_TEST: cond_true = fc || fz;
      CARRY_CLEAR_TEST:            cond_true = !fc;
      CARRY_SET_TEST:              cond_true = fc;
      ZERO_CLEAR_TEST:             cond_true = !fz;
      ZERO_SET_TEST:               cond_true = fz;
      OVERFLOW_CLEAR_TEST:         cond_true = !fv;
      OVERFLOW_SET_TEST:           cond_true = fv;
      POSITIVE_TEST:               cond_true = !fn;
      NEGATIVE_TEST:               cond_true = fn;
      SIGNED_NOT_LESS_TEST:        cond_true = fn == fv;
      SIGNED_BELOW_TEST:           cond_true = fn != fv;
      SIGNED_ABOVE_TEST:           cond_true = !fz && fn == fv;
      SIGNED_NOT_ABOVE_TEST:       cond_true = fz || fn != fv;
      default:                     cond_true = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (op_valid_in) state_nxt = ST_DEC;
      ST_DEC: begin
        if (!op_ok)               state_nxt = ST_IDLE;
        else if (ext_need != 2'h0) state_nxt = ST_EXT;
        else if (need_mem)        state_nxt = ST_MEM;
        else if (is_sh)           state_nxt = ST_SHIFT;
        else                      state_nxt = ST_EXEC;
      end
      ST_EXT: begin
        if (ext_valid_in && ext_left_r == 2'h1)
          state_nxt = need_mem ? ST_MEM : ST_EXEC;
      end
      ST_MEM:   if (mem_valid_in) state_nxt = is_sh ? ST_SHIFT : ST_EXEC;
      ST_SHIFT: if (cnt_r == 6'h00) state_nxt = ST_EXEC;
      ST_EXEC:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_r <= 16'h0000;
      pc_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && op_valid_in) begin
      op_r <= opcode_in;
      pc_r <= pc_in;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_r      <= 32'h0000_0000;
      ext_left_r <= 2'h0;
    end else if (state_r == ST_DEC) begin
      ext_r      <= 32'h0000_0000;
      ext_left_r <= ext_need;
    end else if (state_r == ST_EXT && ext_valid_in) begin
      ext_r      <= {ext_r[15:0], ext_word_in};
      ext_left_r <= ext_left_r - 2'h1;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      orig_r <= 32'h0000_0000;
      opnd_r <= 32'h0000_0000;
    end else if (state_r == ST_DEC) begin
      orig_r <= dst_reg;
      opnd_r <= sext(dst_reg, size);
    end else if (state_r == ST_MEM && mem_valid_in) begin
      orig_r <= {16'h0000, mem_rdata_in};
      opnd_r <= sext({16'h0000, mem_rdata_in}, size);
    end else if (state_r == ST_SHIFT && cnt_r != 6'h00) begin
      opnd_r <= opnd_step;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r     <= 6'h00;
      v_r       <= 1'b0;
      last_r    <= 1'b0;
      shifted_r <= 1'b0;
    end else if (state_r == ST_DEC) begin
      cnt_r     <= cnt_load;
      v_r       <= 1'b0;
      last_r    <= 1'b0;
      shifted_r <= 1'b0;
    end else if (state_r == ST_SHIFT && cnt_r != 6'h00) begin
      cnt_r     <= cnt_r - 6'h01;
      v_r       <= v_r | (left & msb_chg);
      last_r    <= out_bit;
      shifted_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------------
  wire exec = state_r == ST_EXEC;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_ready_out <= 1'b1;
      ext_req_out  <= 1'b0;
      mem_req_out  <= 1'b0;
      done_out     <= 1'b0;
      illegal_out  <= 1'b0;
      flags_we_out <= 1'b0;
      dreg_we_out  <= 1'b0;
      mem_wr_out   <= 1'b0;
      pc_we_out    <= 1'b0;
    end else begin
      op_ready_out <= state_nxt == ST_IDLE;
      ext_req_out  <= state_nxt == ST_EXT;
      mem_req_out  <= state_nxt == ST_MEM;
      done_out     <= exec | (state_r == ST_DEC && !op_ok);
      illegal_out  <= state_r == ST_DEC && !op_ok;
      flags_we_out <= exec && !is_br;
      dreg_we_out  <= exec && (is_rsh || (is_bit && !bit_mem));
      mem_wr_out   <= exec && need_mem;
      pc_we_out    <= exec && is_br;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_out     <= 5'h00;
      dreg_idx_out  <= 3'h0;
      dreg_data_out <= 32'h0000_0000;
      mem_byte_out  <= 1'b0;
      mem_wdata_out <= 16'h0000;
      pc_out        <= 32'h0000_0000;
    end else if (exec) begin
      flags_out     <= is_sh ? sh_flags : bit_flags;
      dreg_idx_out  <= ea_reg;
      dreg_data_out <= is_sh ? sh_res : bit_res;
      mem_byte_out  <= is_bit;
      mem_wdata_out <= is_sh ? sh_res[15:0] : {8'h00, bit_res[7:0]};
      pc_out        <= pc_target;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_imm_count_eight:
    assert property (state_r == ST_DEC && is_rsh && !op_r[5] &&
                     op_r[11:9] == 3'h0 |=> cnt_r == IMM_CNT_MAX)
    else $error("Zero count field did not load eight.");
  a_reg_count_mod:
    assert property (state_r == ST_DEC && is_rsh && op_r[5]
                     |=> cnt_r == $past(cnt_reg_val))
    else $error("Register count not taken modulo 64.");
  a_right_sign_kept:
    assert property (state_r == ST_SHIFT && !left && cnt_r != 6'h00
                     |=> $stable(opnd_r[31]))
    else $error("Right shift lost the sign bit.");
  a_zero_count_flags:
    assert property (exec && is_sh && !shifted_r |=> !flags_out[FLG_C] &&
                     flags_out[FLG_X] == $past(flags_in[FLG_X]))
    else $error("Zero count changed X or left C set.");
  a_right_no_ovf:
    assert property (exec && is_sh && !left |=> !flags_out[FLG_V])
    else $error("Right shift reported overflow.");
  a_branch_keeps_flags:
    assert property (exec && is_br |=> pc_we_out && !flags_we_out ##1
                     !pc_we_out)
    else $error("Branch wrote flags or missed its pc write.");
  a_short_branch_pc:
    assert property (exec && is_br && cond_true && ext_need == 2'h0
                     |=> pc_out == $past(pc_r) + PC_STEP +
                         {{24{$past(op_r[7])}}, $past(op_r[7:0])})
    else $error("Taken short branch went to a wrong target.");
  a_fall_through_pc:
    assert property (exec && is_br && !cond_true
                     |=> pc_out == $past(pc_fall))
    else $error("Untaken branch did not skip extension words.");
  a_bit_zero_flag:
    assert property (exec && is_bit |=> flags_out[FLG_Z] == !$past(tested)
                     && flags_out[FLG_N] == $past(flags_in[FLG_N]))
    else $error("Bit test flag update is wrong.");
  a_mem_mode_check:
    assert property (state_r == ST_DEC && is_msh && !mem_alt
                     |=> illegal_out && done_out ##1 !done_out)
    else $error("Bad memory shift mode was not refused.");
  a_word_disp_fetch:
    assert property (state_r == ST_DEC && op_ok && is_br && word_disp
                     |=> ext_req_out)
    else $error("Zero displacement did not fetch an extension word.");

  c_taken_long: cover property (exec && is_br && long_disp && cond_true);
  c_mem_bit:    cover property (exec && is_bit && bit_mem);
  c_big_shift:  cover property (state_r == ST_DEC && is_rsh &&
                                cnt_load > IMM_CNT_MAX);
  c_left_ovf:   cover property (exec && is_sh && left && v_r);

endmodule // sbx_exec

`default_nettype wire

/* tb/sbx_exec_test.sv */
// Self-checking bench for the shift, branch and bit test-and-invert unit.
`timescale 1ns/100ps
`default_nettype none
module shift_branch_bittest_exec_test;
  import sbx_pkg::*;
  logic         clock_in = 1'b0, sys_rst_in = 1'b1, op_valid_in = 1'b0;
  logic [15:0]  opcode_in = 16'h0000, ext_word_in = 16'h0000;
  logic [15:0]  mem_rdata_in = 16'h0000;
  logic [31:0]  pc_in = 32'h0000_0000;
  logic [4:0]   flags_in = 5'h00;
  logic [255:0] dfile = '0;
  logic         ext_valid_in = 1'b0, mem_valid_in = 1'b0;
  logic         op_ready_out, ext_req_out, mem_req_out, done_out, illegal_out;
  logic         flags_we_out, dreg_we_out, mem_wr_out, mem_byte_out, pc_we_out;
  logic [4:0]   flags_out, g_fl;
  logic [2:0]   dreg_idx_out;
  logic [31:0]  dreg_data_out, pc_out, g_dd, g_pc;
  logic [15:0]  mem_wdata_out, g_md;
  logic         g_ill, g_fwe, g_dwe, g_mwr, g_mb, g_pwe;
  logic [2:0]   g_idx;
  int           fail_count = 0, n_tests = 0, cyc = 0;

  sbx_exec sbx_exec_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .op_valid_in(op_valid_in), .opcode_in(opcode_in), .pc_in(pc_in),
    .flags_in(flags_in), .dreg_file_in(dfile), .ext_valid_in(ext_valid_in),
    .ext_word_in(ext_word_in), .mem_valid_in(mem_valid_in),
    .mem_rdata_in(mem_rdata_in), .op_ready_out(op_ready_out),
    .ext_req_out(ext_req_out), .mem_req_out(mem_req_out),
    .done_out(done_out), .illegal_out(illegal_out),
    .flags_we_out(flags_we_out), .flags_out(flags_out),
    .dreg_we_out(dreg_we_out), .dreg_idx_out(dreg_idx_out),
    .dreg_data_out(dreg_data_out), .mem_wr_out(mem_wr_out),
    .mem_byte_out(mem_byte_out), .mem_wdata_out(mem_wdata_out),
    .pc_we_out(pc_we_out), .pc_out(pc_out));

  always #4 clock_in = ~clock_in;
  // A hung handshake must still reach the closing report.
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Offers one opcode, serves extension words and the operand read, and
  // latches the one-cycle results at the done pulse.
  task automatic run(input logic [15:0] op, input logic [31:0] pc,
                     input logic [4:0] fl, input logic [15:0] w0, w1, md);
    int k;
    logic [15:0] q[$];
    q = '{w0, w1};
    @(negedge clock_in);
    op_valid_in = 1'b1; opcode_in = op; pc_in = pc; flags_in = fl;
    @(negedge clock_in);
    op_valid_in = 1'b0;
    for (k = 0; k < 200 && done_out !== 1'b1; k++) begin
      ext_valid_in = (ext_req_out === 1'b1) && (q.size() > 0);
      if (ext_valid_in) ext_word_in = q.pop_front();
      mem_valid_in = (mem_req_out === 1'b1);
      mem_rdata_in = md;
      @(negedge clock_in);
    end
    ext_valid_in = 1'b0; mem_valid_in = 1'b0;
    chk_w({done_out, op_ready_out}, 2'b11);
    g_ill = illegal_out; g_fwe = flags_we_out; g_fl = flags_out;
    g_dwe = dreg_we_out; g_idx = dreg_idx_out; g_dd = dreg_data_out;
    g_mwr = mem_wr_out; g_mb = mem_byte_out; g_md = mem_wdata_out;
    g_pwe = pc_we_out; g_pc = pc_out;
  endtask
  function automatic logic cond_ok(input logic [3:0] c, input logic [4:0] f);
    logic n, z, v, cy;
    {n, z, v, cy} = f[3:0];
    case (c)
      4'h2: return !cy && !z;   4'h3: return cy || z;
      4'h4: return !cy;         4'h5: return cy;
      4'h6: return !z;          4'h7: return z;
      4'h8: return !v;          4'h9: return v;
      4'ha: return !n;          4'hb: return n;
      4'hc: return n == v;      4'hd: return n != v;
      4'he: return !z && n == v;
      default: return z || n != v;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reg_shifts();
    dfile[32+:32] = 32'h1234_5681;
    run(16'he201, 32'h0, 5'h00, 16'h0, 16'h0, 16'h0);
    chk_w(g_dd & MASK_BYTE, 32'h0000_00c0);
    chk_w(g_fl, 5'h19);
    chk_w({g_dwe, g_fwe, g_idx}, 5'h19);
    dfile[64+:32] = 32'h0000_4001;
    run(16'he142, 32'h0, 5'h00, 16'h0, 16'h0, 16'h0);
    chk_w(g_dd & MASK_WORD, 32'h0000_0100);
    chk_w(g_fl, 5'h02);
    dfile[96+:32] = 32'h0000_0040;
    dfile[128+:32] = 32'h8000_0000;
    run(16'he6a4, 32'h0, 5'h11, 16'h0, 16'h0, 16'h0);
    chk_w(g_dd, 32'h8000_0000);
    chk_w(g_fl, 5'h18);
    dfile[96+:32] = 32'h0000_0049;
    run(16'he6a4, 32'h0, 5'h11, 16'h0, 16'h0, 16'h0);
    chk_w({g_dd, g_fl}, {32'hffc0_0000, 5'h08});
  endtask
  task automatic t_mem_shifts();
    run(16'he1d3, 32'h0, 5'h00, 16'h0, 16'h0, 16'h8000);
    chk_w({g_mwr, g_mb, g_md, g_fl}, {2'b10, 16'h0, 5'h17});
    run(16'he0f9, 32'h0, 5'h00, 16'h0, 16'h0, 16'h8001);
    chk_w({g_mwr, g_md, g_fl}, {1'b1, 16'hc000, 5'h19});
  endtask
  task automatic t_illegal();
    logic [15:0] ops[6] = '{16'he1c3, 16'he1cb, 16'he1fc, 16'he1fa, 16'h6102,
                            16'h0b48};
    foreach (ops[i]) begin
      run(ops[i], 32'h0, 5'h00, 16'h0, 16'h0, 16'h0);
      chk_w({g_ill, g_dwe, g_mwr, g_pwe}, 4'h8);
    end
  endtask
  task automatic br(input logic [3:0] c, input logic [7:0] d8,
                    input logic [15:0] w0, w1, input logic [4:0] fl);
    logic [31:0] disp, step;
    disp = d8 == DISP_WORD ? {{16{w0[15]}}, w0} :
           d8 == DISP_LONG ? {w0, w1} : {{24{d8[7]}}, d8};
    step = d8 == DISP_WORD ? 32'h4 : d8 == DISP_LONG ? 32'h6 : 32'h2;
    run({OP_BRANCH, c, d8}, 32'h0000_1000, fl, w0, w1, 16'h0);
    chk_w({g_pwe, g_ill}, 2'b10);
    chk_w(g_pc, cond_ok(c, fl) ? 32'h1002 + disp : 32'h1000 + step);
    chk_w(g_fwe, 1'b0);
  endtask
  task automatic t_branches();
    logic [4:0] fls[4] = '{5'h00, 5'h0f, 5'h0a, 5'h04};
    foreach (fls[f])
      for (int c = 2; c < 16; c++) br(c[3:0], 8'hfe, 16'h0, 16'h0, fls[f]);
    br(ZERO_SET_TEST, 8'h00, 16'h0000, 16'h0, 5'h04);
    br(ZERO_SET_TEST, 8'h00, 16'h0010, 16'h0, 5'h04);
    br(ZERO_SET_TEST, 8'h00, 16'h0010, 16'h0, 5'h00);
    br(ZERO_SET_TEST, 8'hff, 16'hffff, 16'hfff0, 5'h04);
    br(ZERO_SET_TEST, 8'hff, 16'hffff, 16'hfff0, 5'h00);
  endtask
  task automatic t_bit_ops();
    dfile[160+:32] = 32'd33;
    dfile[192+:32] = 32'h0000_0002;
    run(16'h0b46, 32'h0, 5'h1f, 16'h0, 16'h0, 16'h0);
    chk_w({g_dwe, g_idx, g_dd, g_fl}, {4'he, 32'h0, 5'h1b});
    dfile[192+:32] = 32'h0000_0000;
    run(16'h0846, 32'h0, 5'h00, 16'h001f, 16'h0, 16'h0);
    chk_w({g_dd, g_fl}, {32'h8000_0000, 5'h04});
    run(16'h0850, 32'h0, 5'h1b, 16'h000b, 16'h0, 16'h00f7);
    chk_w({g_mwr, g_mb, g_md[7:0], g_fl}, {2'b11, 8'hff, 5'h1f});
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    t_reg_shifts();
    t_mem_shifts();
    t_illegal();
    t_branches();
    t_bit_ops();
    end_sim();
  end
endmodule // shift_branch_bittest_exec_test
`default_nettype wire
